/* File: hw/fault_alarm.sv */
// Negative compliance and reference overcurrent alarms with output scaling.
// Notes on behaviour
// - Enabling ch0 monitoring onto a negative output: alarm, monitor off, flag, in order.
// - In that case the analog monitor output is placed in its disabled state.
// - Ch0 going negative after monitoring was enabled: alarm, then flag.
// - In that case the monitor output is driven to the ch0 positive supply.
// - Negative-compliance alarm holds until a status read, which releases it.
// - The ch0 negative-compliance mask keeps that event off the alarm output.
// - Reference overcurrent first switches to the internal set resistor.
// - Then the alarm output asserts, then the reference fault flag sets.
// - After a reference fault, a status read releases the alarm output.
// - The reference overcurrent mask keeps that event off the alarm output.
// - Scale codes reset to zero; higher codes lower full scale monotonically.
// - Negative compliance is detected on channel 0 only, and only while sinking.
// - The shared alarm output is active low, optionally open drain.
// - Open-drain operation is off after reset until the host enables it.
`timescale 1ns/10ps
module fault_alarm
	import fault_alarm_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic ch0_monitor_enable_in,
	input wire logic ch0_output_negative_in,
	input wire logic ch0_sinking_in,
	input wire logic reference_overcurrent_in,
	input wire logic ch0_negative_compliance_mask_in,
	input wire logic reference_overcurrent_mask_in,
	input wire logic open_drain_write_in,
	input wire logic open_drain_value_in,
	input wire logic status_read_in,
	input wire logic range_write_in,
	input wire logic [CHAN_WIDTH-1:0] range_channel_in,
	input wire logic [SCALE_WIDTH-1:0] range_code_in,
	input wire logic data_write_in,
	input wire logic [CHAN_WIDTH-1:0] data_channel_in,
	input wire logic [DATA_WIDTH-1:0] data_value_in,
	output logic alarm_n_out,
	output logic alarm_oe_out,
	output mon_t analog_monitor_output_out,
	output logic use_internal_reference_set_resistor_out,
	output logic ch0_negative_compliance_flag_out,
	output logic reference_overcurrent_flag_out,
	output logic [NUM_CHANNELS-1:0][DATA_WIDTH-1:0] channel_data_out
);
	seq_t neg_state, next_neg_state, ref_state, next_ref_state;
	logic neg_cond_q, next_neg_cond_q, mon_en_q, next_mon_en_q;
	logic ref_q, next_ref_q, neg_disable_case, next_neg_disable_case;
	logic neg_latch, next_neg_latch, ref_latch, next_ref_latch;
	logic next_neg_flag, next_ref_flag, next_reference_set_resistor, next_alarm_n;
	logic open_drain, next_open_drain, next_alarm_oe;
	mon_t next_monitor;
	logic neg_cond, neg_event, ref_event, enable_rise;
	logic [NUM_CHANNELS-1:0][SCALE_WIDTH-1:0] scale_code;
	logic [NUM_CHANNELS-1:0][DATA_WIDTH-1:0] next_channel_data;
	scale_if scaler_link ();

	scale_unit u_scale (
		.link(scaler_link)
	);

	assign neg_cond = ch0_monitor_enable_in && ch0_output_negative_in &&
		ch0_sinking_in;
	assign neg_event = neg_cond && !neg_cond_q;
	assign enable_rise = ch0_monitor_enable_in && !mon_en_q;
	assign ref_event = reference_overcurrent_in && !ref_q;

	always_comb begin
		next_neg_cond_q = neg_cond;
		next_mon_en_q = ch0_monitor_enable_in;
		next_ref_q = reference_overcurrent_in;
		next_neg_state = neg_state;
		next_ref_state = ref_state;
		next_neg_disable_case = neg_disable_case;
		next_reference_set_resistor = use_internal_reference_set_resistor_out;
		next_monitor = analog_monitor_output_out;
		// A status read clears latched events; a set in the same cycle wins.
		next_neg_latch = neg_latch && !status_read_in;
		next_ref_latch = ref_latch && !status_read_in;
		next_neg_flag = ch0_negative_compliance_flag_out && !status_read_in;
		next_ref_flag = reference_overcurrent_flag_out && !status_read_in;
		if (!ch0_monitor_enable_in && neg_state == SEQ_IDLE) begin
			next_monitor = MON_NORMAL;
		end
		unique case (neg_state)
			SEQ_IDLE: begin
				if (neg_event) begin
					next_neg_state = SEQ_STEP1;
					next_neg_disable_case = enable_rise;
				end
			end
			SEQ_STEP1: begin
				next_neg_latch = 1'b1;
				next_neg_state = SEQ_STEP2;
			end
			SEQ_STEP2: begin
				if (neg_disable_case) begin
					next_monitor = MON_DISABLED;
				end else begin
					next_monitor = MON_SUPPLY;
				end
				next_neg_state = SEQ_STEP3;
			end
			SEQ_STEP3: begin
				next_neg_flag = 1'b1;
				next_neg_state = SEQ_IDLE;
			end
		endcase
		unique case (ref_state)
			SEQ_IDLE: begin
				if (ref_event) begin
					next_ref_state = SEQ_STEP1;
				end
			end
			SEQ_STEP1: begin
				next_reference_set_resistor = 1'b1;
				next_ref_state = SEQ_STEP2;
			end
			SEQ_STEP2: begin
				next_ref_latch = 1'b1;
				next_ref_state = SEQ_STEP3;
			end
			SEQ_STEP3: begin
				next_ref_flag = 1'b1;
				next_ref_state = SEQ_IDLE;
			end
		endcase
		next_open_drain = open_drain_write_in ? open_drain_value_in :
			open_drain;
		next_alarm_n = !((next_neg_latch && !ch0_negative_compliance_mask_in) ||
			(next_ref_latch && !reference_overcurrent_mask_in));
		// In open-drain mode the pin is only driven while pulling low.
		next_alarm_oe = !next_open_drain || !next_alarm_n;
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			neg_state <= SEQ_IDLE;
			ref_state <= SEQ_IDLE;
			neg_cond_q <= 1'b0;
			mon_en_q <= 1'b0;
			ref_q <= 1'b0;
			neg_disable_case <= 1'b0;
			neg_latch <= 1'b0;
			ref_latch <= 1'b0;
			open_drain <= OPEN_DRAIN_RESET;
			alarm_n_out <= 1'b1;
			alarm_oe_out <= 1'b1;
			analog_monitor_output_out <= MON_NORMAL;
			use_internal_reference_set_resistor_out <= 1'b0;
			ch0_negative_compliance_flag_out <= 1'b0;
			reference_overcurrent_flag_out <= 1'b0;
		end else begin
			neg_state <= next_neg_state;
			ref_state <= next_ref_state;
			neg_cond_q <= next_neg_cond_q;
			mon_en_q <= next_mon_en_q;
			ref_q <= next_ref_q;
			neg_disable_case <= next_neg_disable_case;
			neg_latch <= next_neg_latch;
			ref_latch <= next_ref_latch;
			open_drain <= next_open_drain;
			alarm_n_out <= next_alarm_n;
			alarm_oe_out <= next_alarm_oe;
			analog_monitor_output_out <= next_monitor;
			use_internal_reference_set_resistor_out <= next_reference_set_resistor;
			ch0_negative_compliance_flag_out <= next_neg_flag;
			reference_overcurrent_flag_out <= next_ref_flag;
		end
	end

	// Scaling is sourcing only, so a sinking channel 0 passes data unscaled.
	always_comb begin
		scaler_link.code = scale_code[0];
		for (int i = 0; i < NUM_CHANNELS; i++) begin
			if (data_channel_in == CHAN_WIDTH'(i)) begin
				scaler_link.code = scale_code[i];
			end
		end
		scaler_link.raw = data_value_in;
		scaler_link.bypass = (data_channel_in == '0) && ch0_sinking_in;
	end

	for (genvar g = 0; g < NUM_CHANNELS; g++) begin : g_chan
		logic [SCALE_WIDTH-1:0] next_code;
		always_comb begin
			next_code = scale_code[g];
			next_channel_data[g] = channel_data_out[g];
			if (range_write_in && range_channel_in == CHAN_WIDTH'(g)) begin
				next_code = range_code_in;
			end
			if (data_write_in && data_channel_in == CHAN_WIDTH'(g)) begin
				next_channel_data[g] = scaler_link.scaled;
			end
		end
		always_ff @(posedge clock_in or negedge rst_n_in) begin
			if (!rst_n_in) begin
				scale_code[g] <= SCALE_CODE_RESET;
				channel_data_out[g] <= '0;
			end else begin
				scale_code[g] <= next_code;
				channel_data_out[g] <= next_channel_data[g];
			end
		end
	end

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence neg_start;
		neg_state == SEQ_IDLE && neg_event;
	endsequence
	sequence neg_alarm_then_monitor(mon_t m);
		neg_latch ##1 analog_monitor_output_out == m;
	endsequence

	AST_NEG_ENABLE_ORDER: assert property (
		neg_start and enable_rise |=> ##1 neg_alarm_then_monitor(MON_DISABLED)
		##1 ch0_negative_compliance_flag_out)
		else $error("Enable-onto-negative sequence out of order.");
	AST_NEG_DISABLE: assert property (
		neg_state == SEQ_STEP2 && neg_disable_case |=>
		analog_monitor_output_out == MON_DISABLED)
		else $error("Monitor output not disabled.");
	AST_NEG_LATE_ORDER: assert property (
		neg_start and !enable_rise |=> ##1 neg_alarm_then_monitor(MON_SUPPLY)
		##1 ch0_negative_compliance_flag_out)
		else $error("Late negative sequence out of order.");
	AST_NEG_CLAMP: assert property (
		neg_state == SEQ_STEP2 && !neg_disable_case |=>
		analog_monitor_output_out == MON_SUPPLY)
		else $error("Monitor output not clamped to supply.");
	AST_READ_RELEASE: assert property (
		status_read_in && neg_state != SEQ_STEP1 && ref_state != SEQ_STEP2
		|=> alarm_n_out)
		else $error("Status read did not release the alarm.");
	AST_NEG_MASK: assert property (
		ch0_negative_compliance_mask_in && !ref_latch && ref_state != SEQ_STEP2
		|=> alarm_n_out)
		else $error("Masked negative compliance drove the alarm.");
	AST_REF_ORDER: assert property (
		ref_state == SEQ_IDLE && ref_event |=> ##1 use_internal_reference_set_resistor_out
		##1 ref_latch ##1 reference_overcurrent_flag_out)
		else $error("Reference fault sequence out of order.");
	AST_REF_ALARM: assert property (
		ref_state == SEQ_STEP2 && !reference_overcurrent_mask_in |=> !alarm_n_out)
		else $error("Reference fault did not assert the alarm.");
	AST_REF_MASK: assert property (
		reference_overcurrent_mask_in && !neg_latch && neg_state != SEQ_STEP1
		|=> alarm_n_out)
		else $error("Masked reference fault drove the alarm.");
	AST_SCALE_UNITY: assert property (
		data_write_in && data_channel_in < CHAN_WIDTH'(NUM_CHANNELS) &&
		scaler_link.code == SCALE_CODE_RESET |=>
		channel_data_out[$past(data_channel_in)] == $past(data_value_in))
		else $error("Zero scale code altered the data.");
	AST_NEG_SINK_ONLY: assert property (
		neg_state == SEQ_IDLE && !ch0_sinking_in |=> neg_state == SEQ_IDLE)
		else $error("Negative compliance started while not sinking.");
	AST_OPEN_DRAIN_OFF: assert property (
		!open_drain && !open_drain_write_in |=> alarm_oe_out)
		else $error("Alarm pin released while push-pull.");
	AST_LATCH_HOLD: assert property (
		neg_latch && !status_read_in |=> neg_latch [*2] or status_read_in)
		else $error("Negative event latch dropped without a read.");
endmodule

/* File: hw/fault_alarm_pkg.sv */
// Shared constants and types for the fault alarm and scaling logic.
package fault_alarm_pkg;
	localparam int NUM_CHANNELS = 6;
	localparam int DATA_WIDTH = 14;
	localparam int SCALE_WIDTH = 6;
	localparam int CHAN_WIDTH = 3;
	localparam logic [SCALE_WIDTH-1:0] SCALE_CODE_RESET = 6'h00;
	localparam logic [7:0] SCALE_UNITY = 8'h80;
	localparam int SCALE_SHIFT = 7;
	localparam logic OPEN_DRAIN_RESET = 1'h0;
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_STEP1, SEQ_STEP2, SEQ_STEP3} seq_t;
	typedef enum logic [1:0] {MON_NORMAL, MON_DISABLED, MON_SUPPLY} mon_t;
endpackage

/* File: hw/scale_if.sv */
// Carrier between the alarm block and its full-scale scaling unit.
`timescale 1ns/10ps
interface scale_if;
	import fault_alarm_pkg::*;
	logic [SCALE_WIDTH-1:0] code;
	logic [DATA_WIDTH-1:0] raw;
	logic bypass;
	logic [DATA_WIDTH-1:0] scaled;
	modport requester (output code, output raw, output bypass, input scaled);
	modport scaler (input code, input raw, input bypass, output scaled);
endinterface

/* File: hw/scale_unit.sv */
// Full-scale scaling of one data word by the factor (1 - code/128).
`timescale 1ns/10ps
module scale_unit
	import fault_alarm_pkg::*;
(
	scale_if.scaler link
);
	logic [7:0] factor;
	logic [DATA_WIDTH+7:0] product;

	// The factor never exceeds unity, so the result always fits the data width.
	always_comb begin
		factor = SCALE_UNITY - {2'h0, link.code};
		product = {8'h00, link.raw} * {{DATA_WIDTH{1'b0}}, factor};
		if (link.bypass) begin
			link.scaled = link.raw;
		end else begin
			link.scaled = product[SCALE_SHIFT +: DATA_WIDTH];
		end
	end
endmodule

/* File: testbench/host_model.sv */
// Host model that reads the status register after seeing the alarm.
`timescale 1ns/10ps
module host_model (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic alarm_n_in,
	input wire logic poll_in,
	input wire logic [7:0] wait_in,
	output logic status_read_out
);
	logic [7:0] count;
	// A read is the only way out of a latched alarm, so the host must read.
	always @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count <= 8'h00;
			status_read_out <= 1'h0;
		end else begin
			status_read_out <= 1'h0;
			count <= 8'h00;
			if (poll_in || (!alarm_n_in && count == wait_in)) begin
				status_read_out <= 1'h1;
			end else if (!alarm_n_in) begin
				count <= count + 8'h01;
			end
		end
	end
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the fault alarm and scaling block.
`timescale 1ns/10ps
module tb_top;
	import fault_alarm_pkg::*;
	logic clock_in, rst_n_in, en, neg, sink, ref_oc, mk_n, mk_r;
	logic od_wr, od_val, rd, rg_wr, d_wr, poll;
	logic alarm_n, oe, reference_set_resistor, fl_n, fl_r;
	logic [CHAN_WIDTH-1:0] rg_ch, d_ch;
	logic [SCALE_WIDTH-1:0] rg_code;
	logic [DATA_WIDTH-1:0] d_val;
	logic [NUM_CHANNELS-1:0][DATA_WIDTH-1:0] data;
	logic [7:0] hw;
	mon_t mon;
	int miscompares, total_checks, cycles, seed, od, c;
	int codes [NUM_CHANNELS];
	int exp_d [NUM_CHANNELS];
	fault_alarm uut (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.ch0_monitor_enable_in(en), .ch0_output_negative_in(neg),
		.ch0_sinking_in(sink), .reference_overcurrent_in(ref_oc),
		.ch0_negative_compliance_mask_in(mk_n),
		.reference_overcurrent_mask_in(mk_r), .open_drain_write_in(od_wr),
		.open_drain_value_in(od_val), .status_read_in(rd),
		.range_write_in(rg_wr), .range_channel_in(rg_ch),
		.range_code_in(rg_code), .data_write_in(d_wr),
		.data_channel_in(d_ch), .data_value_in(d_val),
		.alarm_n_out(alarm_n), .alarm_oe_out(oe),
		.analog_monitor_output_out(mon), .use_internal_reference_set_resistor_out(reference_set_resistor),
		.ch0_negative_compliance_flag_out(fl_n),
		.reference_overcurrent_flag_out(fl_r), .channel_data_out(data));
	host_model host (.clock_in(clock_in), .rst_n_in(rst_n_in),
		.alarm_n_in(alarm_n), .poll_in(poll), .wait_in(hw),
		.status_read_out(rd));
	initial begin
		clock_in = 1'h0;
		forever #5 clock_in = ~clock_in;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// The ceiling is far above the few hundred cycles the tests need.
	always @(posedge clock_in) begin
		cycles++;
		if (cycles > 5000) begin
			miscompares++;
			finish_test();
		end
	end
	task automatic chk_bit(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	// Kind 0 is negative compliance, 1 and 2 reference faults (2: reference_set_resistor set).
	task automatic run_seq(input int kind, input mon_t me, input logic mask);
		logic ea;
		// The triggering edge is the first edge of the loop, so k counts from it.
		for (int k = 1; k <= 5; k++) begin
			tick(1);
			ea = !(!mask && k >= (kind != 0 ? 3 : 2));
			chk_bit(alarm_n, ea);
			chk_bit(oe, od != 0 ? !ea : 1'h1);
			chk_bit(kind != 0 ? fl_r : fl_n, k >= 4);
			if (kind != 0) begin
				chk_bit(reference_set_resistor, k >= 2 || kind == 2);
			end else begin
				chk_word(mon, k >= 3 ? me : MON_NORMAL);
			end
		end
	endtask
	task automatic read_done(input logic p);
		poll = p;
		tick(1);
		poll = 1'h0;
		chk_bit(alarm_n, p);
		tick(12);
		chk_bit(alarm_n, 1'h1);
		chk_bit(fl_n | fl_r, 1'h0);
	endtask
	initial begin
		seed = 66033;
		{rst_n_in, en, neg, sink, ref_oc, mk_n, mk_r, od_wr, od_val} = 9'h000;
		{rg_wr, d_wr, poll, rg_ch, d_ch, rg_code, d_val} = 29'h0000000;
		hw = 8'h04;
		repeat (4) @(posedge clock_in);
		#1 rst_n_in = 1'h1;
		tick(1);
		chk_word({alarm_n, oe, reference_set_resistor, fl_n, fl_r}, 16'h0018);
		chk_word(mon, MON_NORMAL);
		sink = 1'h1;
		neg = 1'h1;
		tick(1);
		en = 1'h1;
		run_seq(0, MON_DISABLED, 1'h0);
		read_done(1'h0);
		{en, neg} = 2'h0;
		hw = 8'h09;
		tick(2);
		en = 1'h1;
		tick(2);
		neg = 1'h1;
		run_seq(0, MON_SUPPLY, 1'h0);
		neg = 1'h0;
		read_done(1'h0);
		en = 1'h0;
		mk_n = 1'h1;
		tick(2);
		en = 1'h1;
		tick(2);
		neg = 1'h1;
		run_seq(0, MON_SUPPLY, 1'h1);
		read_done(1'h1);
		{en, neg, mk_n, sink} = 4'h0;
		tick(2);
		{en, neg} = 2'h3;
		tick(8);
		chk_word({alarm_n, fl_n}, 16'h0002);
		{en, neg, od_wr, od_val} = 4'h3;
		tick(1);
		od_wr = 1'h0;
		od = 1;
		chk_bit(oe, 1'h0);
		ref_oc = 1'h1;
		run_seq(1, MON_NORMAL, 1'h0);
		ref_oc = 1'h0;
		read_done(1'h0);
		{ref_oc, mk_r} = 2'h3;
		run_seq(2, MON_NORMAL, 1'h1);
		read_done(1'h1);
		mk_r = 1'h0;
		for (int i = 0; i < 40; i++) begin
			c = i < NUM_CHANNELS ? i : {$random(seed)} % NUM_CHANNELS;
			if (i >= NUM_CHANNELS) begin
				rg_ch = CHAN_WIDTH'(c);
				rg_code = SCALE_WIDTH'($random(seed));
				codes[c] = int'(rg_code);
				rg_wr = 1'h1;
				tick(1);
				rg_wr = 1'h0;
				chk_word(data[c], 16'(exp_d[c]));
			end
			d_ch = CHAN_WIDTH'(c);
			d_val = DATA_WIDTH'($random(seed));
			exp_d[c] = (int'(d_val) * (128 - codes[c])) >> 7;
			d_wr = 1'h1;
			tick(1);
			d_wr = 1'h0;
			tick(1);
			chk_word(data[c], 16'(exp_d[c]));
		end
		finish_test();
	end
endmodule
